//--- include/rtcr_pkg.sv
// constants for the remote temperature and configuration register bank
// assumes a 10 MHz system clock and a byte-wide register port from bus logic
// Contract
// RULE1 - signed high byte: sign plus 64..1 degrees
// RULE2 - filter on: signed low byte five fraction bits
// RULE3 - filter off: signed low byte three fraction bits
// RULE4 - unsigned high byte: weights 128..1, no sign
// RULE5 - unsigned low byte follows same fraction layout
// RULE6 - high byte read freezes matching low byte
// RULE7 - low byte read releases the freeze
// RULE8 - repeated high reads refreeze newest low byte
// RULE9 - host reads high byte before low byte
// RULE10 - diode config bit 6 selects shared pin role
// RULE11 - diode config bits 5,4 mask diode fault
// RULE12 - diode config bit 3 selects diode model
// RULE13 - bits 2:1 filter: 00 off, 11 on
// RULE14 - diode config bit7 zero, bit0 one, reset 1Fh
// RULE15 - eleven-bit two's-complement offset, resets to zero
// RULE16 - general config bit 6: run or standby
// RULE17 - general config alarm masks, reserved zero, reset 00h
// RULE18 - rate field: continuous, 0.364, 1, 2.5 seconds
// RULE19 - continuous conversion 63 ms, 33 ms on fault
// RULE20 - rate bits 7:2 zero, reset 02h
// RULE21 - one-shot write converts once only in standby
// RULE22 - config and rate reachable at two addresses
// RULE23 - diode fault: unsigned zero, signed -128
// RULE24 - busy flag set while converting
// RULE25 - offset added to every remote measurement
// RULE26 - read-only writes ignored, reserved bits fixed

package rtcr_pkg;

   localparam int unsigned CLK_MHZ = 10;

   // register addresses
   localparam logic [7:0] ADDR_LC_HI   = 8'h00;
   localparam logic [7:0] ADDR_RS_HI   = 8'h01;
   localparam logic [7:0] ADDR_STAT1   = 8'h02;
   localparam logic [7:0] ADDR_GCFG_A  = 8'h03;
   localparam logic [7:0] ADDR_RATE_A  = 8'h04;
   localparam logic [7:0] ADDR_GCFG_B  = 8'h09;
   localparam logic [7:0] ADDR_RATE_B  = 8'h0A;
   localparam logic [7:0] ADDR_ONESHOT = 8'h0F;
   localparam logic [7:0] ADDR_RS_LO   = 8'h10;
   localparam logic [7:0] ADDR_OFF_HI  = 8'h11;
   localparam logic [7:0] ADDR_OFF_LO  = 8'h12;
   localparam logic [7:0] ADDR_LC_LO   = 8'h30;
   localparam logic [7:0] ADDR_RU_HI   = 8'h31;
   localparam logic [7:0] ADDR_RU_LO   = 8'h32;
   localparam logic [7:0] ADDR_DCFG    = 8'hBF;

   // reset values
   localparam logic [7:0] GCFG_RST = 8'h00;
   localparam logic [1:0] RATE_RST = 2'h2;
   localparam logic [7:0] DCFG_RST = 8'h1F;
   localparam logic [7:0] OFF_RST  = 8'h00;

   // writable bits and fixed bits
   localparam logic [7:0] GCFG_WMASK   = 8'h5E;
   localparam logic [7:0] DCFG_WMASK   = 8'h7E;
   localparam logic [7:0] DCFG_FIXED1  = 8'h01;
   localparam logic [7:0] OFFL_WMASK   = 8'hE0;

   // field positions
   localparam int unsigned GCFG_STANDBY  = 6;
   localparam int unsigned GCFG_RTCRIT_M = 4;
   localparam int unsigned GCFG_ROT_M    = 3;
   localparam int unsigned GCFG_LTCRIT_M = 2;
   localparam int unsigned GCFG_LOT_M    = 1;
   localparam int unsigned DCFG_PINSEL   = 6;
   localparam int unsigned DCFG_OTF_M    = 5;
   localparam int unsigned DCFG_TCF_M    = 4;
   localparam int unsigned DCFG_MODEL    = 3;
   localparam int unsigned DCFG_FILT_HI  = 2;
   localparam int unsigned DCFG_FILT_LO  = 1;
   localparam int unsigned STAT1_BUSY    = 7;
   localparam int unsigned OFFL_MSB      = 7;
   localparam int unsigned OFFL_LSB      = 5;

   // encodings
   localparam logic [1:0] FILT_ON   = 2'h3;
   localparam logic [1:0] RATE_CONT = 2'h0;
   localparam logic [1:0] RATE_R1   = 2'h1;
   localparam logic [1:0] RATE_R2   = 2'h2;

   // result limits in 1/32 degree units
   localparam logic signed [14:0] SAT_S_MIN = 15'sh7000;
   localparam logic signed [14:0] SAT_S_MAX = 15'sh0FFF;
   localparam logic signed [14:0] SAT_U_MAX = 15'sh1FFF;
   localparam logic [12:0]        FAULT_S   = 13'h1000;
   localparam logic [12:0]        FAULT_U   = 13'h0000;

   // timing in microseconds, counts derived from the clock rate
   localparam int unsigned CONV_LONG_US  = 63_000;
   localparam int unsigned CONV_SHORT_US = 33_000;
   localparam int unsigned RATE1_US      = 364_000;
   localparam int unsigned RATE2_US      = 1_000_000;
   localparam int unsigned RATE3_US      = 2_500_000;
   localparam int unsigned CONV_LONG_CYC  = CONV_LONG_US * CLK_MHZ;
   localparam int unsigned CONV_SHORT_CYC = CONV_SHORT_US * CLK_MHZ;
   localparam int unsigned RATE1_CYC      = RATE1_US * CLK_MHZ;
   localparam int unsigned RATE2_CYC      = RATE2_US * CLK_MHZ;
   localparam int unsigned RATE3_CYC      = RATE3_US * CLK_MHZ;

   typedef enum logic [1:0] {
      CV_IDLE = 2'b00,
      CV_BUSY = 2'b01,
      CV_WAIT = 2'b10
   } rtcr_conv_e;

endpackage

//--- design/rtcr_top.sv
// remote temperature result, configuration and conversion control registers
// assumes bus logic on clk_sys_i issues one-cycle read and write strobes
// and the measurement path presents results on the same clock
`timescale 1ns/1ps
`default_nettype none

module rtcr_top
   import rtcr_pkg::*;
#(
   parameter int unsigned P_CONV_LONG  = CONV_LONG_CYC,
   parameter int unsigned P_CONV_SHORT = CONV_SHORT_CYC,
   parameter int unsigned P_RATE1      = RATE1_CYC,
   parameter int unsigned P_RATE2      = RATE2_CYC,
   parameter int unsigned P_RATE3      = RATE3_CYC
)(
   input  wire logic        clk_sys_i,
   input  wire logic        reset_n_i,
   input  wire logic        ce_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic        reg_wr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_rd_i,
   output var  logic [7:0]  reg_rdata_o,
   output var  logic        reg_rvalid_o,
   input  wire logic [13:0] meas_remote_i,
   input  wire logic [10:0] meas_local_i,
   input  wire logic        diode_fault_i,
   output var  logic        conv_start_o,
   output var  logic        busy_o,
   output logic             standby_o,
   output logic             shared_pin_function_select_o,
   output logic             overtemp_fault_mask_o,
   output logic             critical_fault_mask_o,
   output logic             diode_model_select_o,
   output logic             remote_filter_sel_hi_o,
   output logic             remote_filter_sel_lo_o,
   output logic             remote_critical_mask_o,
   output logic             remote_overtemp_mask_o,
   output logic             local_critical_mask_o,
   output logic             local_overtemp_mask_o,
   output logic [1:0]       conv_rate_o
);

   localparam int unsigned CW = $clog2(P_RATE3 + 1);

   generate
      if (P_CONV_SHORT < 1 || P_CONV_LONG < P_CONV_SHORT || P_RATE1 <= P_CONV_LONG
          || P_RATE2 < P_RATE1 || P_RATE3 < P_RATE2)
      begin : g_bad_timing
         $error("rtcr_top: timing parameters out of order");
      end
   endgenerate

   // address match against either of two aliases
   function automatic logic rtcr_hit2(input logic [7:0] a,
                                      input logic [7:0] x,
                                      input logic [7:0] y);
      rtcr_hit2 = (a == x) || (a == y);
   endfunction

   // low byte layout: five or three fraction bits, rest zero
   function automatic logic [7:0] rtcr_lo(input logic [4:0] frac,
                                          input logic       filt);
      if (filt)
      begin
         rtcr_lo = {frac, 3'h0};
      end
      else
      begin
         rtcr_lo = {frac[4:2], 5'h00};
      end
   endfunction

   // clamp to signed range -128 .. +127.96875
   function automatic logic [12:0] rtcr_sat_s(input logic signed [14:0] v);
      if (v < SAT_S_MIN)
      begin
         rtcr_sat_s = SAT_S_MIN[12:0];
      end
      else if (v > SAT_S_MAX)
      begin
         rtcr_sat_s = SAT_S_MAX[12:0];
      end
      else
      begin
         rtcr_sat_s = v[12:0];
      end
   endfunction

   // clamp to unsigned range 0 .. 255.96875
   function automatic logic [12:0] rtcr_sat_u(input logic signed [14:0] v);
      if (v < 15'sh0000)
      begin
         rtcr_sat_u = 13'h0000;
      end
      else if (v > SAT_U_MAX)
      begin
         rtcr_sat_u = SAT_U_MAX[12:0];
      end
      else
      begin
         rtcr_sat_u = v[12:0];
      end
   endfunction

   logic [7:0]        gcfg_q;
   logic [1:0]        rate_q;
   logic [7:0]        dcfg_q;
   logic [7:0]        offh_q;
   logic [7:0]        offl_q;
   logic [7:0]        rs_hi_q;
   logic [7:0]        rs_lo_q;
   logic [7:0]        ru_hi_q;
   logic [7:0]        ru_lo_q;
   logic [7:0]        lc_hi_q;
   logic [7:0]        lc_lo_q;
   logic [7:0]        frz_q [3];
   logic [2:0]        lk_q;
   rtcr_conv_e        st_q;
   logic [CW-1:0]     el_q;
   logic [CW-1:0]     len_q;
   logic              one_q;
   logic              wr_w;
   logic              rd_w;
   logic              oneshot_w;
   logic              filt_w;
   logic              done_w;
   logic              start_w;
   logic [CW-1:0]     ivl_w;
   logic signed [14:0] off_w;
   logic signed [14:0] sum_w;
   logic [12:0]       s_w;
   logic [12:0]       u_w;
   logic [7:0]        lo_live_w [3];
   logic [7:0]        rd_d;

   localparam logic [7:0] LK_HI [3] = '{ADDR_RS_HI, ADDR_RU_HI, ADDR_LC_HI};
   localparam logic [7:0] LK_LO [3] = '{ADDR_RS_LO, ADDR_RU_LO, ADDR_LC_LO};

   assign wr_w      = ce_i && reg_wr_i;
   assign rd_w      = ce_i && reg_rd_i;
   assign oneshot_w = wr_w && (reg_addr_i == ADDR_ONESHOT) && gcfg_q[GCFG_STANDBY]; // RULE21
   assign filt_w    = (dcfg_q[DCFG_FILT_HI:DCFG_FILT_LO] == FILT_ON);             // RULE13

   // configuration outputs come straight from the register flops
   assign standby_o                    = gcfg_q[GCFG_STANDBY];
   assign remote_critical_mask_o       = gcfg_q[GCFG_RTCRIT_M];
   assign remote_overtemp_mask_o       = gcfg_q[GCFG_ROT_M];
   assign local_critical_mask_o        = gcfg_q[GCFG_LTCRIT_M];
   assign local_overtemp_mask_o        = gcfg_q[GCFG_LOT_M];
   assign shared_pin_function_select_o = dcfg_q[DCFG_PINSEL];   // RULE10
   assign overtemp_fault_mask_o        = dcfg_q[DCFG_OTF_M];    // RULE11
   assign critical_fault_mask_o        = dcfg_q[DCFG_TCF_M];    // RULE11
   assign diode_model_select_o         = dcfg_q[DCFG_MODEL];    // RULE12
   assign remote_filter_sel_hi_o       = dcfg_q[DCFG_FILT_HI];
   assign remote_filter_sel_lo_o       = dcfg_q[DCFG_FILT_LO];
   assign conv_rate_o                  = rate_q;

   // host-writable registers
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         gcfg_q <= GCFG_RST;   // RULE17
         rate_q <= RATE_RST;   // RULE20
         dcfg_q <= DCFG_RST;   // RULE14
         offh_q <= OFF_RST;    // RULE15
         offl_q <= OFF_RST;    // RULE15
      end
      else if (wr_w)
      begin
         if (rtcr_hit2(reg_addr_i, ADDR_GCFG_A, ADDR_GCFG_B))   // RULE22
         begin
            gcfg_q <= reg_wdata_i & GCFG_WMASK;   // RULE17 RULE26
         end
         if (rtcr_hit2(reg_addr_i, ADDR_RATE_A, ADDR_RATE_B))   // RULE22
         begin
            rate_q <= reg_wdata_i[1:0];   // RULE20
         end
         if (reg_addr_i == ADDR_DCFG)
         begin
            dcfg_q <= (reg_wdata_i & DCFG_WMASK) | DCFG_FIXED1;   // RULE14 RULE26
         end
         if (reg_addr_i == ADDR_OFF_HI)
         begin
            offh_q <= reg_wdata_i;   // RULE15
         end
         if (reg_addr_i == ADDR_OFF_LO)
         begin
            offl_q <= reg_wdata_i & OFFL_WMASK;   // RULE15
         end
      end
   end

   // remote reading in 1/32 degree units plus offset in 1/8 degree units times four
   assign off_w = 15'($signed({offh_q, offl_q[OFFL_MSB:OFFL_LSB]}));
   assign sum_w = 15'($signed(meas_remote_i)) + (off_w <<< 2);   // RULE25
   assign s_w   = diode_fault_i ? FAULT_S : rtcr_sat_s(sum_w);   // RULE23
   assign u_w   = diode_fault_i ? FAULT_U : rtcr_sat_u(sum_w);   // RULE23

   // conversion interval for the programmed rate
   always_comb
   begin
      case (rate_q)   // RULE18
         RATE_R1: ivl_w = CW'(P_RATE1);
         RATE_R2: ivl_w = CW'(P_RATE2);
         default: ivl_w = CW'(P_RATE3);
      endcase
   end

   assign done_w = (st_q == CV_BUSY) && (el_q == len_q - CW'(1));

   // decide when a new conversion begins
   always_comb
   begin
      case (st_q)
         CV_IDLE: start_w = !gcfg_q[GCFG_STANDBY] || oneshot_w;   // RULE16 RULE21
         CV_BUSY:
         begin
            start_w = done_w && !one_q && !gcfg_q[GCFG_STANDBY]
                      && (rate_q == RATE_CONT);   // RULE18
         end
         CV_WAIT: start_w = !gcfg_q[GCFG_STANDBY] && (el_q >= ivl_w - CW'(1));   // RULE18
         default: start_w = 1'b0;
      endcase
   end

   // conversion sequencer
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         st_q         <= CV_IDLE;
         el_q         <= '0;
         len_q        <= '0;
         one_q        <= 1'b0;
         conv_start_o <= 1'b0;
         busy_o       <= 1'b0;
      end
      else if (ce_i)
      begin
         conv_start_o <= 1'b0;
         if (start_w)
         begin
            st_q         <= CV_BUSY;
            el_q         <= '0;
            len_q        <= diode_fault_i ? CW'(P_CONV_SHORT) : CW'(P_CONV_LONG);   // RULE19
            one_q        <= gcfg_q[GCFG_STANDBY];   // RULE21
            conv_start_o <= 1'b1;
            busy_o       <= 1'b1;   // RULE24
         end
         else
         begin
            case (st_q)
               CV_IDLE:
               begin
                  el_q <= '0;
               end
               CV_BUSY:
               begin
                  el_q <= el_q + CW'(1);
                  if (done_w)
                  begin
                     busy_o <= 1'b0;   // RULE24
                     st_q   <= (one_q || gcfg_q[GCFG_STANDBY]) ? CV_IDLE : CV_WAIT;
                  end
               end
               CV_WAIT:
               begin
                  el_q <= el_q + CW'(1);
                  if (gcfg_q[GCFG_STANDBY])
                  begin
                     st_q <= CV_IDLE;   // RULE16
                  end
               end
               default:
               begin
                  st_q   <= CV_IDLE;
                  busy_o <= 1'b0;
               end
            endcase
         end
      end
   end

   // result registers, updated at the end of each conversion
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         rs_hi_q <= 8'h00;
         rs_lo_q <= 8'h00;
         ru_hi_q <= 8'h00;
         ru_lo_q <= 8'h00;
         lc_hi_q <= 8'h00;
         lc_lo_q <= 8'h00;
      end
      else if (ce_i && done_w)
      begin
         rs_hi_q <= s_w[12:5];                  // RULE1
         rs_lo_q <= rtcr_lo(s_w[4:0], filt_w);  // RULE2 RULE3
         ru_hi_q <= u_w[12:5];                  // RULE4
         ru_lo_q <= rtcr_lo(u_w[4:0], filt_w);  // RULE5
         lc_hi_q <= meas_local_i[10:3];
         lc_lo_q <= {meas_local_i[2:0], 5'h00};
      end
   end

   assign lo_live_w[0] = rs_lo_q;
   assign lo_live_w[1] = ru_lo_q;
   assign lo_live_w[2] = lc_lo_q;

   // low byte freeze on high byte read, release on low byte read
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         lk_q <= 3'h0;
         for (int k = 0; k < 3; k++)
         begin
            frz_q[k] <= 8'h00;
         end
      end
      else if (rd_w)
      begin
         for (int k = 0; k < 3; k++)
         begin
            if (reg_addr_i == LK_HI[k])
            begin
               frz_q[k] <= lo_live_w[k];   // RULE6 RULE8
               lk_q[k]  <= 1'b1;           // RULE6
            end
            else if (reg_addr_i == LK_LO[k])
            begin
               lk_q[k] <= 1'b0;   // RULE7
            end
         end
      end
   end

   // read data selection; unmapped and write-only addresses read 00h
   always_comb
   begin
      case (reg_addr_i)
         ADDR_LC_HI: rd_d = lc_hi_q;
         ADDR_LC_LO: rd_d = lk_q[2] ? frz_q[2] : lc_lo_q;   // RULE6
         ADDR_RS_HI: rd_d = rs_hi_q;
         ADDR_RS_LO: rd_d = lk_q[0] ? frz_q[0] : rs_lo_q;   // RULE6
         ADDR_RU_HI: rd_d = ru_hi_q;
         ADDR_RU_LO: rd_d = lk_q[1] ? frz_q[1] : ru_lo_q;   // RULE6
         ADDR_STAT1:
         begin
            rd_d = 8'h00;
            rd_d[STAT1_BUSY] = busy_o;   // RULE24
         end
         ADDR_GCFG_A, ADDR_GCFG_B: rd_d = gcfg_q;   // RULE22
         ADDR_RATE_A, ADDR_RATE_B: rd_d = {6'h00, rate_q};   // RULE20 RULE22
         ADDR_DCFG: rd_d = dcfg_q;
         ADDR_OFF_HI: rd_d = offh_q;
         ADDR_OFF_LO: rd_d = offl_q;
         default: rd_d = 8'h00;
      endcase
   end

   // registered read answer, one cycle after the strobe
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         reg_rdata_o  <= 8'h00;
         reg_rvalid_o <= 1'b0;
      end
      else if (ce_i)
      begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i)
         begin
            reg_rdata_o <= rd_d;
         end
      end
   end

endmodule

`default_nettype wire

//--- verification/rtcr_props.sv
// assertions on the register port and conversion control of rtcr_top
// assumes a bind into rtcr_top with the same conversion lengths
`timescale 1ns/1ps
`default_nettype none
module rtcr_props
   import rtcr_pkg::*;
#(
   parameter int unsigned P_CONV_LONG  = 20,
   parameter int unsigned P_CONV_SHORT = 10
)(
   input wire logic       clk_sys_i,
   input wire logic       reset_n_i,
   input wire logic       ce_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic       reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       reg_rd_i,
   input wire logic       reg_rvalid_o,
   input wire logic       conv_start_o,
   input wire logic       busy_o,
   input wire logic       standby_o,
   input wire logic       remote_critical_mask_o,
   input wire logic       remote_overtemp_mask_o,
   input wire logic       local_critical_mask_o,
   input wire logic       local_overtemp_mask_o,
   input wire logic [1:0] conv_rate_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   logic        gcfg_wr;
   logic        rate_wr;
   logic        shot_wr;
   int unsigned busy_cnt_q;
   assign gcfg_wr = ce_i && reg_wr_i && (reg_addr_i == ADDR_GCFG_A || reg_addr_i == ADDR_GCFG_B);
   assign rate_wr = ce_i && reg_wr_i && (reg_addr_i == ADDR_RATE_A || reg_addr_i == ADDR_RATE_B);
   assign shot_wr = ce_i && reg_wr_i && reg_addr_i == ADDR_ONESHOT;
   // length of the running conversion in cycles
   always_ff @(posedge clk_sys_i)
      if (!reset_n_i)
         busy_cnt_q <= 0;
      else if (conv_start_o && ce_i)
         busy_cnt_q <= 1;
      else if (busy_o && ce_i)
         busy_cnt_q <= busy_cnt_q + 1;
   sequence s_gcfg_wr;
      gcfg_wr;
   endsequence
   sequence s_rate_wr;
      rate_wr;
   endsequence
   a_read_answer: assert property (ce_i && reg_rd_i |=> reg_rvalid_o)
      else $error("read strobe not answered");
   a_standby_write: assert property (s_gcfg_wr |=> standby_o == $past(reg_wdata_i[6]))
      else $error("standby bit not stored");
   a_alarm_mask_write: assert property (s_gcfg_wr |=> {remote_critical_mask_o,
      remote_overtemp_mask_o, local_critical_mask_o, local_overtemp_mask_o} == $past(reg_wdata_i[4:1]))
      else $error("alarm masks not stored");
   a_rate_write: assert property (s_rate_wr |=> conv_rate_o == $past(reg_wdata_i[1:0]))
      else $error("rate field not stored");
   a_config_hold: assert property (!gcfg_wr |=> $stable(standby_o))
      else $error("standby changed without write");
   a_start_busy: assert property (conv_start_o |-> busy_o)
      else $error("busy low at conversion start");
   a_standby_start: assert property (conv_start_o && $past(standby_o) |-> $past(shot_wr))
      else $error("conversion started in standby without trigger");
   a_conv_length: assert property ($fell(busy_o) |->
      busy_cnt_q == P_CONV_LONG || busy_cnt_q == P_CONV_SHORT)
      else $error("conversion length wrong");
endmodule
`default_nettype wire

//--- verification/rtcr_host_model.sv
// host side of the register port: one-cycle read and write strobes
// assumes the bench calls its tasks and the device answers reads next cycle
`timescale 1ns/1ps
`default_nettype none
module rtcr_host_model (
   input  wire logic       clk_sys_i,
   output logic [7:0]      reg_addr_o,
   output logic            reg_wr_o,
   output logic [7:0]      reg_wdata_o,
   output logic            reg_rd_o,
   input  wire logic [7:0] reg_rdata_i,
   input  wire logic       reg_rvalid_i
);
   initial
   begin
      reg_addr_o  = 8'h00;
      reg_wr_o    = 1'b0;
      reg_wdata_o = 8'h00;
      reg_rd_o    = 1'b0;
   end
   // released lines show the inverse of the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_i);
      reg_addr_o  = a;
      reg_wdata_o = d;
      reg_wr_o    = 1'b1;
      @(negedge clk_sys_i);
      reg_wr_o    = 1'b0;
      reg_addr_o  = ~a;
      reg_wdata_o = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(negedge clk_sys_i);
      reg_addr_o = a;
      reg_rd_o   = 1'b1;
      @(negedge clk_sys_i);
      reg_rd_o   = 1'b0;
      reg_addr_o = ~a;
      d          = reg_rdata_i;
      v          = reg_rvalid_i;
   endtask
endmodule
`default_nettype wire

//--- verification/rtcr_tb_top.sv
// self-checking bench for rtcr_top with shortened conversion counts
// assumes rtcr_props and rtcr_host_model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module rtcr_tb_top;
   import rtcr_pkg::*;
   localparam int unsigned LNG = 20, SHT = 10, R1 = 50, R2 = 80, R3 = 120;
   localparam logic [7:0] RST_A [10] = '{ADDR_STAT1, ADDR_GCFG_A, ADDR_GCFG_B, ADDR_RATE_A,
      ADDR_RATE_B, ADDR_DCFG, ADDR_OFF_HI, ADDR_OFF_LO, ADDR_ONESHOT, 8'h55};
   localparam logic [7:0] RST_V [10] = '{8'h80, 8'h00, 8'h00, 8'h02, 8'h02, 8'h1F, 8'h00, 8'h00,
      8'h00, 8'h00};
   localparam logic [7:0] RES_A [6] = '{ADDR_RS_HI, ADDR_RS_LO, ADDR_RU_HI, ADDR_RU_LO,
      ADDR_LC_HI, ADDR_LC_LO};
   logic        clk_sys_i = 1'b0;
   logic        reset_n_i, ce_i, reg_wr_i, reg_rd_i, reg_rvalid_o, diode_fault_i;
   logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, oh, ol, dc, d;
   logic [13:0] meas_remote_i;
   logic [10:0] meas_local_i;
   logic        conv_start_o, busy_o, standby_o, shared_pin_function_select_o, v;
   logic        overtemp_fault_mask_o, critical_fault_mask_o, diode_model_select_o;
   logic        remote_filter_sel_hi_o, remote_filter_sel_lo_o, remote_critical_mask_o;
   logic        remote_overtemp_mask_o, local_critical_mask_o, local_overtemp_mask_o;
   logic [1:0]  conv_rate_o;
   logic [47:0] ex, ex_a;
   int          fails = 0, num_checks = 0, cyc = 0, dummy, n;
   always #50 clk_sys_i = ~clk_sys_i;
   rtcr_top #(.P_CONV_LONG(LNG), .P_CONV_SHORT(SHT), .P_RATE1(R1), .P_RATE2(R2), .P_RATE3(R3))
   DUT (
      .clk_sys_i, .reset_n_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
      .reg_rdata_o, .reg_rvalid_o, .meas_remote_i, .meas_local_i, .diode_fault_i,
      .conv_start_o, .busy_o, .standby_o, .shared_pin_function_select_o,
      .overtemp_fault_mask_o, .critical_fault_mask_o, .diode_model_select_o,
      .remote_filter_sel_hi_o, .remote_filter_sel_lo_o, .remote_critical_mask_o,
      .remote_overtemp_mask_o, .local_critical_mask_o, .local_overtemp_mask_o, .conv_rate_o);
   rtcr_host_model host (.clk_sys_i, .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
      .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o),
      .reg_rvalid_i(reg_rvalid_o));
   // {signed hi, signed lo, unsigned hi, unsigned lo, local hi, local lo}
   function automatic logic [47:0] exp_res(logic [13:0] m, logic [7:0] h, logic [7:0] l,
                                           logic [10:0] lm, logic filt, logic flt);
      int s, u;
      logic [12:0] sv, uv;
      logic [7:0]  fm;
      s = $signed(m) + 4 * $signed({h, l[7:5]});
      u = s < 0 ? 0 : (s > 8191 ? 8191 : s);
      s = s < -4096 ? -4096 : (s > 4095 ? 4095 : s);
      sv = s[12:0];
      uv = u[12:0];
      fm = filt ? 8'hF8 : 8'hE0;
      if (flt)
         return {32'h8000_0000, lm[10:3], lm[2:0], 5'h00};
      return {sv[12:5], {sv[4:0], 3'h0} & fm, uv[12:5], {uv[4:0], 3'h0} & fm,
              lm[10:3], lm[2:0], 5'h00};
   endfunction
   task automatic end_of_test;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] expd);
      num_checks++;
      if (seen !== expd)
      begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, expd);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, d, v);
      check({7'h00, v}, 8'h01);
      check(d, e);
   endtask
   task automatic wait_idle;
      for (int i = 0; i < 500 && busy_o !== 1'b0; i++)
         @(negedge clk_sys_i);
   endtask
   task automatic wait_start(output int k);
      k = 0;
      do
      begin
         @(negedge clk_sys_i);
         k++;
      end
      while (conv_start_o !== 1'b1 && k < 400);
   endtask
   task automatic conv;
      int k;
      host.wr(ADDR_ONESHOT, 8'($urandom));
      check({6'h00, conv_start_o, busy_o}, 8'h03);
      k = 0;
      while (busy_o === 1'b1 && k < 500)
      begin
         k++;
         @(negedge clk_sys_i);
      end
      check(8'(k), diode_fault_i ? 8'(SHT) : 8'(LNG));
      ex = exp_res(meas_remote_i, oh, ol, meas_local_i, dc[2:1] == 2'h3, diode_fault_i);
   endtask
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         end_of_test;
      end
   end
   initial
   begin
      dummy = $urandom(68675);
      ce_i = 1'b1;
      reset_n_i = 1'b0;
      meas_remote_i = 14'h0000;
      meas_local_i = 11'h000;
      diode_fault_i = 1'b0;
      repeat (4) @(negedge clk_sys_i);
      reset_n_i = 1'b1;
      for (int i = 0; i < 10; i++)
         rdchk(RST_A[i], RST_V[i]);
      host.wr(ADDR_GCFG_A, 8'h40);
      check({7'h00, standby_o}, 8'h01);
      wait_idle;
      host.wr(ADDR_GCFG_B, 8'hFF);
      rdchk(ADDR_GCFG_A, 8'h5E);
      host.wr(ADDR_RATE_A, 8'hFF);
      rdchk(ADDR_RATE_B, 8'h03);
      host.wr(ADDR_DCFG, 8'h80);
      rdchk(ADDR_DCFG, 8'h01);
      host.wr(ADDR_OFF_LO, 8'hFF);
      rdchk(ADDR_OFF_LO, 8'hE0);
      host.wr(ADDR_RS_HI, 8'h55);
      rdchk(ADDR_RS_HI, 8'h00);
      ce_i = 1'b0;
      host.wr(ADDR_GCFG_A, 8'h00);
      ce_i = 1'b1;
      rdchk(ADDR_GCFG_B, 8'h5E);
      for (int i = 0; i < 6; i++)
      begin
         dc = {1'b0, 4'($urandom), 2'(i), 1'b1};
         oh = i == 5 ? 8'h00 : 8'($urandom_range(0, 16)) - 8'h08;
         ol = 8'($urandom);
         meas_remote_i = i == 5 ? 14'h1FFF : 14'($urandom_range(0, 12000)) - 14'h1770;
         meas_local_i = 11'($urandom);
         diode_fault_i = i == 4;
         host.wr(ADDR_DCFG, dc);
         check({2'h0, shared_pin_function_select_o, overtemp_fault_mask_o,
            critical_fault_mask_o, diode_model_select_o, remote_filter_sel_hi_o,
            remote_filter_sel_lo_o}, {2'h0, dc[6:1]});
         host.wr(ADDR_OFF_HI, oh);
         host.wr(ADDR_OFF_LO, ol);
         conv;
         for (int j = 0; j < 6; j++)
            rdchk(RES_A[j], ex[47 - 8 * j -: 8]);
      end
      diode_fault_i = 1'b0;
      meas_remote_i = 14'h0123;
      conv;
      ex_a = ex;
      rdchk(ADDR_RS_HI, ex_a[47:40]);
      meas_remote_i = 14'h0137;
      conv;
      rdchk(ADDR_RS_LO, ex_a[39:32]);
      rdchk(ADDR_RS_LO, ex[39:32]);
      rdchk(ADDR_RS_HI, ex[47:40]);
      meas_remote_i = 14'h014B;
      conv;
      rdchk(ADDR_RS_HI, ex[47:40]);
      rdchk(ADDR_RS_LO, ex[39:32]);
      host.wr(ADDR_GCFG_A, 8'h00);
      host.wr(ADDR_ONESHOT, 8'hA5);
      check({7'h00, conv_start_o}, 8'h00);
      for (int r = 3; r >= 0; r--)
      begin
         host.wr(ADDR_RATE_B, 8'(r));
         wait_start(n);
         wait_start(n);
         check(8'(n), 8'(r == 3 ? R3 : r == 2 ? R2 : r == 1 ? R1 : LNG));
      end
      end_of_test;
   end
endmodule
bind rtcr_top rtcr_props #(.P_CONV_LONG(P_CONV_LONG), .P_CONV_SHORT(P_CONV_SHORT)) u_props (.*);
`default_nettype wire
